/* design/adcs_defines.svh */
// Offsets, field positions, reset values and timing counts of the scan converter.
// Assumes byte addresses on an 8-bit APB address and 32-bit data.
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_SEL 8'h04
`define ADCS_OFF_PFM 8'h08
`define ADCS_OFF_PFT 8'h0c
`define ADCS_OFF_STAT 8'h10
`define ADCS_OFF_MASK 8'h14
`define ADCS_OFF_CUR 8'h18
`define ADCS_OFF_RES 8'h80

`define ADCS_CTRL_EN 0
`define ADCS_CTRL_MODE 1
`define ADCS_CTRL_BUSY 3
`define ADCS_PFM_EN 0
`define ADCS_PFM_LT 1
`define ADCS_STAT_END 0

`define ADCS_LAST_CH 5'h17
`define ADCS_PFT_RST 8'h00
`define ADCS_SAR_MSB 4'h9

`define ADCS_CLK_NS 10
`define ADCS_SAMPLE_NS 40
`define ADCS_SAMPLE_CYC ((`ADCS_SAMPLE_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)

`endif

/* design/adcs_pkg.sv */
// Types shared by the scan converter control and its conversion engine.
// Assumes the constants header is compiled alongside.
`default_nettype none
package adcs_pkg;
    typedef enum logic [1:0] {
        ADCS_MODE_CSEL,
        ADCS_MODE_CSCAN,
        ADCS_MODE_OSCAN,
        ADCS_MODE_RSVD
    } adcs_mode_t;

    typedef enum logic [1:0] {
        ADCS_SAR_IDLE,
        ADCS_SAR_SAMP,
        ADCS_SAR_CONV
    } adcs_sar_state_t;

    typedef struct packed {
        logic done;
        logic [9:0] data;
    } adcs_sar_res_t;
endpackage : adcs_pkg
`default_nettype wire

/* design/adcs_sar.sv */
// Successive approximation engine: sample phase, then one bit per cycle.
// Assumes an external comparator reports analog input >= DAC code.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module adcs_sar
(
    input wire logic ref_clk, // Clock.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic start, // Begin a conversion.
    input wire logic stop, // Abort any conversion.
    input wire logic cmp_hi, // Comparator: input >= DAC.
    output logic sample, // Sample and hold active.
    output logic [9:0] dac, // Trial DAC code.
    output adcs_pkg::adcs_sar_res_t res // Done pulse and result.
);
    import adcs_pkg::*;

    adcs_sar_state_t state;
    logic [3:0] cnt;
    logic [3:0] bitp;
    logic [9:0] trial;

    assign trial = cmp_hi ? dac : (dac & ~(10'h001 << bitp));

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state <= ADCS_SAR_IDLE;
            cnt <= 4'h0;
            bitp <= 4'h0;
            dac <= 10'h000;
            sample <= 1'b0;
            res <= '0;
        end
        else if (ce)
        begin
            res.done <= 1'b0;
            if (stop)
            begin
                state <= ADCS_SAR_IDLE;
                sample <= 1'b0;
            end
            else if (start)
            begin
                state <= ADCS_SAR_SAMP;
                cnt <= 4'(`ADCS_SAMPLE_CYC - 1);
                sample <= 1'b1;
            end
            else
            begin
                case (state)
                    ADCS_SAR_SAMP:
                    begin
                        if (cnt == 4'h0)
                        begin
                            sample <= 1'b0;
                            state <= ADCS_SAR_CONV;
                            dac <= 10'h200;
                            bitp <= `ADCS_SAR_MSB;
                        end
                        else
                        begin
                            cnt <= cnt - 4'h1;
                        end
                    end
                    ADCS_SAR_CONV:
                    begin
                        if (bitp == 4'h0)
                        begin
                            res.done <= 1'b1;
                            res.data <= trial;
                            state <= ADCS_SAR_IDLE;
                        end
                        else
                        begin
                            dac <= trial | (10'h001 << (bitp - 4'h1));
                            bitp <= bitp - 4'h1;
                        end
                    end
                    default:
                    begin
                        state <= ADCS_SAR_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : adcs_sar
`default_nettype wire

/* design/adcs_top.sv */
// Scan and threshold-interrupt control of a 10-bit converter, with APB slave.
// Assumes an analog mux driven by ana_sel and a comparator returning cmp_hi.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module adcs_top
(
    input wire logic ref_clk, // Clock, 100 MHz.
    input wire logic rstn, // Synchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error, unmapped address.
    input wire logic cmp_hi, // Comparator: input >= DAC.
    output logic [4:0] ana_sel, // Analog input being converted.
    output logic [9:0] dac_code, // Trial DAC code.
    output logic sample_en, // Sample and hold active.
    output logic irq // Conversion-end interrupt, level.
);
    import adcs_pkg::*;

    // ********************************************
    // Registers and bus decode
    // ********************************************
    logic enable;
    adcs_mode_t mode;
    logic [4:0] last_ch;
    logic pf_en;
    logic pf_lt;
    logic [7:0] pf_thr;
    logic end_flag;
    logic end_mask;
    logic running;
    logic kick;
    logic sar_start;
    logic sar_stop;
    logic [9:0] result [0:23];
    adcs_sar_res_t sar_res;

    logic acc;
    logic wr;
    logic ctrl_wr;
    logic sel_wr;
    logic cfg_wr;
    logic stat_wr;
    logic hit;
    logic [31:0] rd_val;
    logic [4:0] res_idx;

    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign ctrl_wr = wr && (paddr == `ADCS_OFF_CTRL);
    assign sel_wr = wr && (paddr == `ADCS_OFF_SEL);
    assign stat_wr = wr && (paddr == `ADCS_OFF_STAT);
    assign cfg_wr = ctrl_wr || sel_wr || (wr && (paddr == `ADCS_OFF_PFM))
        || (wr && (paddr == `ADCS_OFF_PFT));
    assign res_idx = paddr[6:2];

    always_comb
    begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == `ADCS_OFF_CTRL)
        begin
            rd_val[`ADCS_CTRL_EN] = enable;
            rd_val[`ADCS_CTRL_MODE +: 2] = mode;
            rd_val[`ADCS_CTRL_BUSY] = running;
        end
        else if (paddr == `ADCS_OFF_SEL)
        begin
            rd_val[4:0] = last_ch;
        end
        else if (paddr == `ADCS_OFF_PFM)
        begin
            rd_val[`ADCS_PFM_EN] = pf_en;
            rd_val[`ADCS_PFM_LT] = pf_lt;
        end
        else if (paddr == `ADCS_OFF_PFT)
        begin
            rd_val[7:0] = pf_thr;
        end
        else if (paddr == `ADCS_OFF_STAT)
        begin
            rd_val[`ADCS_STAT_END] = end_flag;
        end
        else if (paddr == `ADCS_OFF_MASK)
        begin
            rd_val[`ADCS_STAT_END] = end_mask;
        end
        else if (paddr == `ADCS_OFF_CUR)
        begin
            rd_val[4:0] = ana_sel;
        end
        else if (paddr[7] && (paddr[1:0] == 2'b00) && (res_idx <= `ADCS_LAST_CH))
        begin
            rd_val[9:0] = result[res_idx];
        end
        else
        begin
            hit = 1'b0;
        end
    end

    // One wait state: ready rises at the end of the first access cycle.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready)
            begin
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= !hit;
            end
            else
            begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            enable <= 1'b0;
            mode <= ADCS_MODE_CSEL;
            last_ch <= 5'h00;
            pf_en <= 1'b0;
            pf_lt <= 1'b0;
            pf_thr <= `ADCS_PFT_RST;
            end_mask <= 1'b0;
        end
        else if (ce && wr)
        begin
            if (paddr == `ADCS_OFF_CTRL)
            begin
                enable <= pwdata[`ADCS_CTRL_EN];
                mode <= adcs_mode_t'(pwdata[`ADCS_CTRL_MODE +: 2]);
            end
            else if (paddr == `ADCS_OFF_SEL)
            begin
                // Values past the last input clamp to it.
                last_ch <= (pwdata[4:0] > `ADCS_LAST_CH) ? `ADCS_LAST_CH : pwdata[4:0];
            end
            else if (paddr == `ADCS_OFF_PFM)
            begin
                pf_en <= pwdata[`ADCS_PFM_EN];
                pf_lt <= pwdata[`ADCS_PFM_LT];
            end
            else if (paddr == `ADCS_OFF_PFT)
            begin
                pf_thr <= pwdata[7:0];
            end
            else if (paddr == `ADCS_OFF_MASK)
            begin
                end_mask <= pwdata[`ADCS_STAT_END];
            end
        end
    end

    // ********************************************
    // Scan sequencer
    // ********************************************
    logic scan;
    logic at_last;
    logic cont;
    logic step;
    logic [7:0] hi;
    logic match;
    logic conv_evt;

    assign scan = (mode != ADCS_MODE_CSEL);
    assign cont = (mode == ADCS_MODE_CSEL) || (mode == ADCS_MODE_CSCAN);
    assign at_last = (ana_sel == last_ch);
    assign step = ce && running && sar_res.done && !cfg_wr && !kick;
    assign hi = sar_res.data[9:2];
    assign match = pf_lt ? (hi < pf_thr) : (hi >= pf_thr);

    always_comb
    begin
        if (!sar_res.done)
        begin
            conv_evt = 1'b0;
        end
        else if (!pf_en)
        begin
            conv_evt = !scan || at_last;
        end
        else
        begin
            conv_evt = match && (!scan || (ana_sel == 5'h00));
        end
    end

    // A config write takes a cycle to settle, so the restart uses the new values.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            running <= 1'b0;
            kick <= 1'b0;
            ana_sel <= 5'h00;
            sar_start <= 1'b0;
            sar_stop <= 1'b0;
        end
        else if (ce)
        begin
            sar_start <= 1'b0;
            sar_stop <= 1'b0;
            if (ctrl_wr && !pwdata[`ADCS_CTRL_EN])
            begin
                running <= 1'b0;
                kick <= 1'b0;
                sar_stop <= 1'b1;
            end
            else if (cfg_wr && (running || ctrl_wr))
            begin
                kick <= 1'b1;
                sar_stop <= 1'b1;
            end
            else if (kick)
            begin
                kick <= 1'b0;
                running <= 1'b1;
                ana_sel <= scan ? 5'h00 : last_ch;
                sar_start <= 1'b1;
            end
            else if (running && sar_res.done)
            begin
                if (scan && !at_last)
                begin
                    ana_sel <= ana_sel + 5'h01;
                    sar_start <= 1'b1;
                end
                else if (!cont)
                begin
                    running <= 1'b0;
                end
                else
                begin
                    ana_sel <= scan ? 5'h00 : last_ch;
                    sar_start <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            for (int i = 0; i <= 23; i++)
            begin
                result[i] <= 10'h000;
            end
        end
        else if (ce && sar_res.done)
        begin
            result[ana_sel] <= sar_res.data;
        end
    end

    // ********************************************
    // Interrupt
    // ********************************************
    // A completion in the clearing cycle still sets the flag.
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            end_flag <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            end_flag <= conv_evt
                || (end_flag && !(stat_wr && pwdata[`ADCS_STAT_END]));
            irq <= end_flag && end_mask;
        end
    end

    adcs_sar u_sar
    (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .start(sar_start),
        .stop(sar_stop),
        .cmp_hi(cmp_hi),
        .sample(sample_en),
        .dac(dac_code),
        .res(sar_res)
    );

    // ********************************************
    // Assertions
    // ********************************************
    default clocking adcs_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    AST_SCAN_STEP:
    assert property (step && scan && !at_last |=> ana_sel == $past(ana_sel) + 5'h01)
    else $error("Scan did not advance to next channel.");

    AST_STORE:
    assert property (ce && sar_res.done |=> result[$past(ana_sel)] == $past(sar_res.data))
    else $error("Result not stored in its channel register.");

    AST_CSCAN_WRAP:
    assert property (step && mode == ADCS_MODE_CSCAN && at_last
        |=> ana_sel == 5'h00 && sar_start && running)
    else $error("Continuous scan did not restart at channel 0.");

    AST_OSCAN_HALT:
    assert property (step && mode == ADCS_MODE_OSCAN && at_last
        |=> !running ##1 !sample_en)
    else $error("One-shot scan did not stop.");

    AST_NOCMP_FLAG:
    assert property (ce && sar_res.done && !pf_en && !scan |=> end_flag ##1 (irq || !$past(end_mask)))
    else $error("Completion without compare did not set flag.");

    AST_CMP_GE:
    assert property (ce && sar_res.done && pf_en && !pf_lt && !scan && !end_flag
        && (sar_res.data[9:2] < pf_thr) |=> !end_flag)
    else $error("Below threshold set flag under >= condition.");

    AST_CMP_LT:
    assert property (ce && sar_res.done && pf_en && pf_lt && !scan
        && (sar_res.data[9:2] < pf_thr) |=> end_flag)
    else $error("Below threshold did not set flag under < condition.");

    AST_CSEL_CONT:
    assert property (step && mode == ADCS_MODE_CSEL && pf_en |=> sar_start && ana_sel == last_ch)
    else $error("Select mode with compare did not continue.");

    AST_SCAN_CH0_ONLY:
    assert property (ce && sar_res.done && pf_en && scan && ana_sel != 5'h00 && !end_flag
        |=> !end_flag)
    else $error("Nonzero channel decided the interrupt in scan.");

    AST_SEL_KEEPS_FLAG:
    assert property (ce && sel_wr && end_flag |=> end_flag)
    else $error("Channel select write cleared the end flag.");

    AST_DISABLE_STOPS:
    assert property (ce && ctrl_wr && !pwdata[`ADCS_CTRL_EN] ##1 ce
        |=> !running && !sample_en && !sar_res.done)
    else $error("Clearing enable did not stop the converter.");

    AST_RESTART:
    assert property (ce && cfg_wr && running && !(ctrl_wr && !pwdata[`ADCS_CTRL_EN])
        ##1 ce |=> sar_start && running)
    else $error("Config write did not restart conversion.");
endmodule : adcs_top
`default_nettype wire

/* verif/adc_scan_and_threshold_irq_bench.sv */
// Self-checking bench for the scan converter control, driven over APB.
// Assumes the comparator is ideal, so each result equals the level set per channel.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defines.svh"
module adc_scan_and_threshold_irq_bench;
    import adcs_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_hi;
    logic [4:0] ana_sel;
    logic [9:0] dac_code;
    logic sample_en;
    logic irq;
    logic [9:0] lv [0:31];
    logic [31:0] rdv;
    logic err;
    int errors = 0;
    int samples_checked = 0;
    int samp_cyc = 0;

    // The comparator answers combinationally from the selected level.
    // Only analog levels reach the inputs; no port traffic shares the pins.
    assign cmp_hi = (lv[ana_sel] >= dac_code);

    // Sample cycles seen, so a scan can be checked for converting each channel once.
    always @(posedge ref_clk)
        if (sample_en === 1'b1)
            samp_cyc <= samp_cyc + 1;

    always #5 ref_clk = ~ref_clk;

    adcs_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_hi(cmp_hi), .ana_sel(ana_sel), .dac_code(dac_code),
        .sample_en(sample_en), .irq(irq));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task report_and_stop;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    task check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : check_word

    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : check_bit

    // Signals change by NBA after an edge; pready is read at the edge before
    // the slave's own updates land, so the sampled value is the settled one.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              output logic [31:0] r, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            report_and_stop();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rdv, err);
    endtask : wr

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000, rdv, err);
        check_word(rdv, exp);
    endtask : rd_chk

    // Reads until the masked value matches; running out of tries counts an error and stops the run.
    task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, a, 32'h00000000, rdv, err);
            n++;
        end
        while ((rdv & m) !== exp && n < 400);
        if ((rdv & m) !== exp)
        begin
            errors++;
            report_and_stop();
        end
        check_word(rdv & m, exp);
    endtask : poll

    function automatic logic [7:0] ra(input int ch);
        return 8'(`ADCS_OFF_RES + 4 * ch);
    endfunction : ra

    task restart(input logic [31:0] ctrl);
        wr(`ADCS_OFF_CTRL, 32'h00000000);
        wr(`ADCS_OFF_STAT, 32'h00000001);
        wr(`ADCS_OFF_CTRL, ctrl);
    endtask : restart

    initial
    begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [7:0] pft_tab [0:3];
        logic [1:0] pfm_tab [0:3];
        logic exp_tab [0:3];
        int base;
        for (int i = 0; i < 32; i++)
            lv[i] = 10'(10'h040 + i * 10'h021);
        pft_tab = '{8'h81, 8'h80, 8'h80, 8'h81};
        pfm_tab = '{2'h1, 2'h1, 2'h3, 2'h3};
        exp_tab = '{1'b0, 1'b1, 1'b0, 1'b1};
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk(`ADCS_OFF_PFT, 32'h00000000);
        for (int a = 0; a < 8'h1c; a += 4)
            rd_chk(8'(a), 32'h00000000);
        rd_chk(ra(23), 32'h00000000);
        xfer(1'b0, 8'h40, 32'h00000000, rdv, err);
        check_bit(err, 1'b1);
        check_word(rdv, 32'h00000000);
        wr(`ADCS_OFF_MASK, 32'h00000001);
        // One-shot scans with a single channel and with four channels.
        // The four-channel pass uses the spare mode code, which also runs one-shot.
        for (int s = 0; s < 4; s += 3)
        begin
            wr(`ADCS_OFF_SEL, 32'(s));
            base = samp_cyc;
            restart((s == 0) ? 32'h00000005 : 32'h00000007);
            poll(`ADCS_OFF_STAT, 32'h00000001, 32'h00000001);
            poll(`ADCS_OFF_CTRL, 32'h00000008, 32'h00000000);
            check_word(32'(samp_cyc - base), 32'((s + 1) * `ADCS_SAMPLE_CYC));
            for (int c = 0; c <= s; c++)
                rd_chk(ra(c), {22'h0, lv[c]});
            rd_chk(ra(s + 1), 32'h00000000);
            check_bit(irq, 1'b1);
        end
        // Continuous scan wraps back to channel 0 and interrupts each pass.
        wr(`ADCS_OFF_SEL, 32'h00000002);
        restart(32'h00000003);
        poll(`ADCS_OFF_STAT, 32'h00000001, 32'h00000001);
        wr(`ADCS_OFF_STAT, 32'h00000001);
        lv[0] <= 10'h2a5;
        poll(ra(0), 32'h000003ff, 32'h000002a5);
        poll(`ADCS_OFF_STAT, 32'h00000001, 32'h00000001);
        wr(`ADCS_OFF_SEL, 32'h00000001);
        rd_chk(`ADCS_OFF_STAT, 32'h00000001);
        wr(`ADCS_OFF_MASK, 32'h00000000);
        rd_chk(`ADCS_OFF_MASK, 32'h00000000);
        check_bit(irq, 1'b0);
        wr(`ADCS_OFF_MASK, 32'h00000001);
        // Clearing enable freezes the results.
        wr(`ADCS_OFF_CTRL, 32'h00000000);
        poll(`ADCS_OFF_CTRL, 32'h00000008, 32'h00000000);
        wr(`ADCS_OFF_STAT, 32'h00000001);
        lv[1] <= 10'h3c3;
        for (int i = 0; i < 20; i++)
            rd_chk(ra(1), {22'h0, 10'h061});
        rd_chk(`ADCS_OFF_STAT, 32'h00000000);
        // Select mode compare: both conditions on either side of the boundary.
        // Select mode without compare flags the first conversion.
        wr(`ADCS_OFF_SEL, 32'h00000005);
        restart(32'h00000001);
        poll(`ADCS_OFF_STAT, 32'h00000001, 32'h00000001);
        poll(ra(5), 32'h000003ff, 32'h000000e5);
        for (int i = 0; i < 4; i++)
        begin
            lv[5] <= 10'(10'h200 + i);
            wr(`ADCS_OFF_PFM, {30'h0, pfm_tab[i]});
            wr(`ADCS_OFF_PFT, {24'h0, pft_tab[i]});
            restart(32'h00000001);
            poll(ra(5), 32'h000003ff, {22'h0, lv[5]});
            rd_chk(`ADCS_OFF_STAT, {31'h0, exp_tab[i]});
            lv[5] <= 10'(10'h203 - i);
            poll(ra(5), 32'h000003ff, {22'h0, 10'(10'h203 - i)});
            rd_chk(`ADCS_OFF_STAT, {31'h0, exp_tab[i]});
        end
        // Scan compare: only channel 0 decides, every channel is stored.
        // Channel 2 rises only once the scan runs, so its would-be match is really seen.
        lv[0] <= 10'h100;
        wr(`ADCS_OFF_SEL, 32'h00000002);
        wr(`ADCS_OFF_PFM, 32'h00000001);
        wr(`ADCS_OFF_PFT, 32'h00000080);
        restart(32'h00000003);
        lv[2] <= 10'h3fc;
        poll(ra(2), 32'h000003ff, 32'h000003fc);
        lv[1] <= 10'h155;
        poll(ra(1), 32'h000003ff, 32'h00000155);
        rd_chk(ra(0), 32'h00000100);
        rd_chk(`ADCS_OFF_STAT, 32'h00000000);
        lv[0] <= 10'h3f0;
        poll(`ADCS_OFF_STAT, 32'h00000001, 32'h00000001);
        lv[1] <= 10'h0aa;
        lv[2] <= 10'h1bb;
        restart(32'h00000005);
        poll(`ADCS_OFF_CTRL, 32'h00000008, 32'h00000000);
        rd_chk(ra(0), 32'h000003f0);
        rd_chk(ra(1), 32'h000000aa);
        rd_chk(ra(2), 32'h000001bb);
        rd_chk(`ADCS_OFF_STAT, 32'h00000001);
        report_and_stop();
    end
endmodule : adc_scan_and_threshold_irq_bench
`default_nettype wire
